/* irsir_pkg.sv */
// Purpose: constants for the infrared serial encoder/decoder block
// Assumes: 50 MHz system clock, baud enable pulses 16 per serial bit
// Notes: control register reached over classic wishbone, 32-bit data
package irsir_pkg;

  // -------------------------------------------------------------
  // register map
  // -------------------------------------------------------------
  localparam logic [9:0] IRSIR_CTRL_IDX = 10'h0bf; // word index, byte address is four times it
  localparam logic [7:0] IRSIR_CTRL_RESET = 8'h00;
  localparam logic [7:0] IRSIR_CTRL_WMASK = 8'hf7; // bit 3 reserved, read only zero
  localparam int IRSIR_EN_BIT = 0;
  localparam int IRSIR_RXEN_BIT = 1;
  localparam int IRSIR_LOOP_BIT = 2;
  localparam int IRSIR_MIN_LSB = 4;
  localparam int IRSIR_MIN_MSB = 7;

  // -------------------------------------------------------------
  // symbol timing, in baud enable ticks or system clocks
  // -------------------------------------------------------------
  localparam logic [3:0] IRSIR_TX_PULSE_FIRST = 4'h7; // 7 ticks low before pulse
  localparam logic [3:0] IRSIR_TX_PULSE_LAST = 4'h9; // 3 ticks high
  localparam logic [1:0] IRSIR_MIN_LOW_BITS = 2'h3;
  localparam logic [2:0] IRSIR_MAX_PULSE_TICKS = 3'h5;
  localparam logic [2:0] IRSIR_TICK_SAT = 3'h6;
  localparam logic [4:0] IRSIR_RX_HOLD_TICKS = 5'h11; // one bit plus one guard tick

  typedef enum logic [1:0] {
    IRSIR_RX_IDLE = 2'b01,
    IRSIR_RX_HOLD = 2'b10
  } irsir_rx_state_e;

endpackage

/* irsir_pulse_check.sv */
// Purpose: qualifies one received low pulse by its width
// Assumes: rx_i is a registered level, low while a pulse is present
// Notes: accept_o pulses one cycle after the pulse ends
module irsir_pulse_check
  import irsir_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic rx_i,
  input wire logic baud_tick_i,
  input wire logic [3:0] min_pulse_i,
  output logic accept_o
);

  logic prev_reg, prev_next;
  logic [5:0] down_reg, down_next;
  logic [2:0] ticks_reg, ticks_next;
  logic accept_reg, accept_next;
  logic min_met;
  logic max_ok;

  // -------------------------------------------------------------
  // width measurement
  // -------------------------------------------------------------
  // edge mode ignores the down counter entirely
  assign min_met = (min_pulse_i == 4'h0) || (down_reg == 6'h00);
  assign max_ok = (ticks_reg <= IRSIR_MAX_PULSE_TICKS);

  // next values: counters reload whenever the line is high
  always_comb begin
    prev_next = clear_i ? 1'b1 : rx_i;
    down_next = down_reg;
    ticks_next = ticks_reg;
    if (clear_i || rx_i) begin
      down_next = {min_pulse_i, IRSIR_MIN_LOW_BITS};
      ticks_next = 3'h0;
    end else begin
      if (down_reg != 6'h00) begin
        down_next = down_reg - 6'h01;
      end
      // saturate so a very long pulse never wraps back to legal
      if (baud_tick_i && (ticks_reg != IRSIR_TICK_SAT)) begin
        ticks_next = ticks_reg + 3'h1;
      end
    end
    accept_next = !clear_i && rx_i && !prev_reg && min_met && max_ok;
  end

  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= 1'b1;
      down_reg <= 6'h00;
      ticks_reg <= 3'h0;
      accept_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      down_reg <= down_next;
      ticks_reg <= ticks_next;
      accept_reg <= accept_next;
    end
  end

  assign accept_o = accept_reg;

endmodule

/* irsir_endec.sv */
// Purpose: infrared serial encoder/decoder between uart lines and transceiver
// Assumes: baud_tick_i is a one-cycle enable, sixteen per uart bit
// Notes: one 8-bit control register on a classic wishbone slave
module irsir_endec
  import irsir_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // uart side
  input wire logic baud_tick_i,
  input wire logic uart_txd_i,
  output logic uart_rxd_o,
  // transceiver side
  input wire logic infrared_rx_line_i,
  output logic infrared_tx_line_o
);

  // -------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------
  logic [7:0] endec_control_reg, endec_control_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic bus_req;
  logic bus_hit;

  logic endec_enable_bit;
  logic rx_decode_enable;
  logic loop_select;
  logic [3:0] min_pulse;
  logic rx_path_on;

  logic tx_bit_reg, tx_bit_next;
  logic [3:0] tx_phase_reg, tx_phase_next;
  logic tx_out_reg, tx_out_next;

  logic rx_source;
  logic rx_sample_reg, rx_sample_next;
  logic pulse_accept;

  irsir_rx_state_e rx_state_reg, rx_state_next;
  logic [4:0] hold_cnt_reg, hold_cnt_next;
  logic rxd_reg, rxd_next;

  // -------------------------------------------------------------
  // control field decode
  // -------------------------------------------------------------
  assign endec_enable_bit = endec_control_reg[IRSIR_EN_BIT];
  assign rx_decode_enable = endec_control_reg[IRSIR_RXEN_BIT];
  assign loop_select = endec_control_reg[IRSIR_LOOP_BIT];
  assign min_pulse = endec_control_reg[IRSIR_MIN_MSB:IRSIR_MIN_LSB];
  // receive needs both the global and the receive enable
  assign rx_path_on = endec_enable_bit && rx_decode_enable;

  // -------------------------------------------------------------
  // wishbone slave
  // -------------------------------------------------------------
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign bus_hit = (wb_adr_i[11:2] == IRSIR_CTRL_IDX);

  // next values: one wait state, unmapped reads return zero
  always_comb begin
    endec_control_next = endec_control_reg;
    ack_next = bus_req && !ack_reg;
    rdat_next = rdat_reg;
    if (bus_req && !ack_reg) begin
      rdat_next = 32'h0000_0000;
      if (bus_hit) begin
        rdat_next = {24'h00_0000, endec_control_reg};
      end
    end
    // write lands on the edge where the master samples ack high
    if (bus_req && ack_reg && bus_hit && wb_we_i && wb_sel_i[0]) begin
      // reserved bit and upper lanes are dropped
      endec_control_next = wb_dat_i[7:0] & IRSIR_CTRL_WMASK;
    end
  end

  // registers for the bus slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      endec_control_reg <= IRSIR_CTRL_RESET;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      endec_control_reg <= endec_control_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // -------------------------------------------------------------
  // encoder
  // -------------------------------------------------------------
  // a change on the uart line marks a bit boundary; the phase
  // restarts there and free-runs across runs of equal bits
  always_comb begin
    tx_bit_next = tx_bit_reg;
    tx_phase_next = tx_phase_reg;
    if (!endec_enable_bit) begin
      tx_bit_next = 1'b1;
      tx_phase_next = 4'h0;
    end else if (uart_txd_i != tx_bit_reg) begin
      tx_bit_next = uart_txd_i;
      tx_phase_next = 4'h0;
    end else if (baud_tick_i) begin
      tx_phase_next = tx_phase_reg + 4'h1; // wraps every 16 ticks
    end
    // a one stays low; a zero gets the short high pulse
    tx_out_next = endec_enable_bit && !tx_bit_next
                  && (tx_phase_next >= IRSIR_TX_PULSE_FIRST)
                  && (tx_phase_next <= IRSIR_TX_PULSE_LAST);
  end

  // registers for the encoder
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_bit_reg <= 1'b1;
      tx_phase_reg <= 4'h0;
      tx_out_reg <= 1'b0;
    end else begin
      tx_bit_reg <= tx_bit_next;
      tx_phase_reg <= tx_phase_next;
      tx_out_reg <= tx_out_next;
    end
  end

  assign infrared_tx_line_o = tx_out_reg;

  // -------------------------------------------------------------
  // receive input select
  // -------------------------------------------------------------
  // loopback feeds the inverted transmit pulse back as a low pulse;
  // the external pin is ignored meanwhile
  assign rx_source = loop_select ? !tx_out_reg : infrared_rx_line_i;

  // a disabled path samples as idle high, so no edge is seen
  always_comb begin
    rx_sample_next = rx_path_on ? rx_source : 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_sample_reg <= 1'b1;
    end else begin
      rx_sample_reg <= rx_sample_next;
    end
  end

  // -------------------------------------------------------------
  // pulse width qualification
  // -------------------------------------------------------------
  irsir_pulse_check u_pulse_check (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(!rx_path_on),
    .rx_i(rx_sample_reg),
    .baud_tick_i(baud_tick_i),
    .min_pulse_i(min_pulse),
    .accept_o(pulse_accept)
  );

  // -------------------------------------------------------------
  // decoder output state machine
  // -------------------------------------------------------------
  // each accepted pulse holds the uart line low for a bit plus a
  // guard tick, so back-to-back zeros merge without a glitch
  always_comb begin
    rx_state_next = rx_state_reg;
    hold_cnt_next = hold_cnt_reg;
    if (!rx_path_on) begin
      rx_state_next = IRSIR_RX_IDLE;
      hold_cnt_next = 5'h00;
    end else begin
      case (rx_state_reg)
        IRSIR_RX_IDLE: begin
          if (pulse_accept) begin
            rx_state_next = IRSIR_RX_HOLD;
            hold_cnt_next = IRSIR_RX_HOLD_TICKS;
          end
        end
        IRSIR_RX_HOLD: begin
          if (pulse_accept) begin
            hold_cnt_next = IRSIR_RX_HOLD_TICKS;
          end else if (baud_tick_i) begin
            hold_cnt_next = hold_cnt_reg - 5'h01;
            if (hold_cnt_reg == 5'h01) begin
              rx_state_next = IRSIR_RX_IDLE;
            end
          end
        end
        default: begin
          rx_state_next = IRSIR_RX_IDLE;
          hold_cnt_next = 5'h00;
        end
      endcase
    end
    rxd_next = (rx_state_next != IRSIR_RX_HOLD);
  end

  // registers for the decoder output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_state_reg <= IRSIR_RX_IDLE;
      hold_cnt_reg <= 5'h00;
      rxd_reg <= 1'b1;
    end else begin
      rx_state_reg <= rx_state_next;
      hold_cnt_reg <= hold_cnt_next;
      rxd_reg <= rxd_next;
    end
  end

  assign uart_rxd_o = rxd_reg;

endmodule

/* irsir_checker.sv */
// Purpose: port assertions for the infrared encoder/decoder
// Assumes: one clock, synchronous reset
// Notes: control value is shadowed from bus writes
module irsir_checker
  import irsir_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic baud_tick_i,
  input wire logic uart_rxd_o,
  input wire logic infrared_rx_line_i,
  input wire logic infrared_tx_line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ctl;
  logic rx_d;
  logic [5:0] lo_clk, lo_len;
  logic [2:0] lo_tk, lo_tks, hi_tk;
  wire logic hit = wb_adr_i[11:2] == IRSIR_CTRL_IDX;
  wire logic rise = rx_d && lo_clk != 6'h00;
  // shadow, plus receive width counters on a one-clock delayed pin, in step with
  // the decoder's own sample flop; those counts saturate so long pulses stay long, the tx count hi_tk does not
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl <= IRSIR_CTRL_RESET;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && hit && wb_sel_i[0]) begin
      ctl <= wb_dat_i[7:0] & IRSIR_CTRL_WMASK;
    end
    rx_d <= infrared_rx_line_i;
    lo_clk <= rx_d ? 6'h00 : lo_clk + {5'h00, lo_clk != 6'h3f};
    lo_tk <= rx_d ? 3'h0 : lo_tk + {2'h0, baud_tick_i && lo_tk != 3'h7};
    hi_tk <= infrared_tx_line_o ? hi_tk + {2'h0, baud_tick_i} : 3'h0;
    if (rise) begin
      lo_len <= lo_clk;
      lo_tks <= lo_tk;
    end
  end
  sequence s_rx_fall;
    $fell(uart_rxd_o) && !ctl[2];
  endsequence
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_read_value: assert property (wb_ack_o && !wb_we_i && hit |-> wb_dat_o[7:0] == ctl)
    else $error("control read wrong");
  a_unused_zero: assert property (wb_ack_o |-> (wb_dat_o & {24'h0, hit ? 8'hf7 : 8'h00}) == wb_dat_o)
    else $error("unused bits set");
  a_tx_quiet: assert property (!ctl[0] [*3] |-> !infrared_tx_line_o)
    else $error("tx while off");
  a_rx_idle: assert property (!(ctl[0] && ctl[1]) [*3] |-> uart_rxd_o)
    else $error("rx low while off");
  a_tx_width: assert property ($fell(infrared_tx_line_o) |-> hi_tk == 3'h3)
    else $error("tx pulse not 3 ticks");
  a_rx_cause: assert property (s_rx_fall |-> $past(infrared_rx_line_i, 3) && !$past(infrared_rx_line_i, 4))
    else $error("rx low without pulse end");
  a_min_width: assert property (s_rx_fall |-> ctl[7:4] == 4'h0 || lo_len >= {ctl[7:4], 2'b11})
    else $error("narrow pulse accepted");
  a_max_width: assert property (s_rx_fall |-> lo_tks <= IRSIR_MAX_PULSE_TICKS)
    else $error("wide pulse accepted");
  a_edge_accept: assert property (rise && ctl[7:0] == 8'h03 && lo_tk <= 3'h5 |-> ##2 !uart_rxd_o)
    else $error("short pulse dropped");
endmodule
bind irsir_endec irsir_checker u_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .baud_tick_i(baud_tick_i),
  .uart_rxd_o(uart_rxd_o),
  .infrared_rx_line_i(infrared_rx_line_i),
  .infrared_tx_line_o(infrared_tx_line_o)
);

/* irsir_xcvr_model.sv */
// Purpose: transceiver stand-in driving the receive line
// Assumes: flash width given in system clocks
// Notes: idles high as the optical receiver does between flashes; own flash echoes
module irsir_xcvr_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fire_i,
  input wire logic [7:0] width_i,
  input wire logic tx_line_i,
  output logic rx_line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left_reg, left_next;
  // countdown of the flash, line low while it lasts
  always_comb begin
    left_next = left_reg - {7'h0, left_reg != 8'h00};
    if (fire_i) begin
      left_next = width_i;
    end
  end
  always_ff @(posedge clk_i) begin
    left_reg <= rst_i ? 8'h00 : left_next;
  end
  // the transmitter's own flash reaches the receiver, as in external loopback
  assign rx_line_o = (left_reg == 8'h00) && !tx_line_i;
endmodule

/* infrared_sir_endec_test.sv */
// Purpose: self-checking bench for the infrared encoder/decoder
// Assumes: baud tick every fourth clock
// Notes: pulse widths kept away from tick boundaries
module infrared_sir_endec_test
  import irsir_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] CTRL = {IRSIR_CTRL_IDX, 2'b00};
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, baud_tick_i, uart_txd_i;
  logic uart_rxd_o, infrared_rx_line_i, infrared_tx_line_o, fire, lo;
  logic [11:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [7:0] width;
  logic [1:0] tcnt;
  int failures, tests_run, hi;
  irsir_endec u_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .baud_tick_i(baud_tick_i),
    .uart_txd_i(uart_txd_i),
    .uart_rxd_o(uart_rxd_o),
    .infrared_rx_line_i(infrared_rx_line_i),
    .infrared_tx_line_o(infrared_tx_line_o)
  );
  // lines wired straight, as the alternate pin mode does; no modem lines exist to interrupt
  irsir_xcvr_model u_xcvr (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .width_i(width),
    .tx_line_i(infrared_tx_line_o), .rx_line_o(infrared_rx_line_i));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // quarter-rate tick keeps bit times short
  always @(posedge clk_i) begin
    tcnt <= tcnt + 2'h1;
    baud_tick_i <= tcnt == 2'h3;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one classic cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      failures++;
      complete_run();
    end
  endtask
  task automatic watch(input int n);
    repeat (n) begin
      @(posedge clk_i);
      hi += int'(infrared_tx_line_o);
      lo |= !uart_rxd_o;
    end
  endtask
  task automatic pulse(input logic [7:0] w, input logic exp);
    lo = 1'b0;
    fire <= 1'b1;
    width <= w;
    @(posedge clk_i);
    fire <= 1'b0;
    watch(w + 8);
    check("rx low", {31'h0, exp}, {31'h0, lo});
    watch(90);
  endtask
  task automatic zero_bit(input logic [31:0] exp_hi, input logic exp_lo);
    hi = 0;
    lo = 1'b0;
    uart_txd_i <= 1'b0;
    watch(64);
    uart_txd_i <= 1'b1;
    watch(24);
    check("tx high clocks", exp_hi, hi);
    check("loop rx low", {31'h0, exp_lo}, {31'h0, lo});
  endtask
  initial begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, fire, lo, tcnt, baud_tick_i} = '0;
    {wb_adr_i, wb_dat_i, width, failures, tests_run, hi} = '0;
    wb_sel_i = 4'hf;
    uart_txd_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CTRL, 32'h0);
    check("ctrl reset", 32'h0, rd);
    wb(1'b1, CTRL, 32'hfffffff7);
    wb(1'b0, CTRL, 32'h0);
    check("ctrl mask", 32'hf7, rd);
    wb(1'b1, CTRL - 12'h4, 32'hffffffff);
    wb(1'b0, CTRL - 12'h4, 32'h0);
    check("unmapped", 32'h0, rd);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, CTRL, 32'h0);
    check("ctrl rereset", 32'h0, rd);
    $display("registers done");
    zero_bit(0, 1'b0);
    wb(1'b1, CTRL, 32'h1);
    zero_bit(12, 1'b0);
    wb(1'b1, CTRL, 32'h7);
    zero_bit(12, 1'b1);
    watch(60);
    wb(1'b1, CTRL, 32'h3);
    zero_bit(12, 1'b1);
    watch(60);
    $display("encoder done");
    wb(1'b1, CTRL, 32'h1);
    pulse(8, 1'b0);
    wb(1'b1, CTRL, 32'h3);
    pulse(2, 1'b1);
    pulse(40, 1'b0);
    wb(1'b1, CTRL, 32'h23);
    pulse(10, 1'b0);
    pulse(11, 1'b1);
    $display("decoder done");
    complete_run();
  end
endmodule
